// >>> core/emcr_config_regs.sv
// Purpose: Configuration register bank of an industrial Ethernet module inside a motor.
// Assumes: Requests, protocol type, events and flash image come from logic on clk.
// Notes:   Setup, divider and alias take effect only from the flash image at boot.
//
// Operation
// [R1] Under the ring protocol the netmask reads 255.255.255.0 and ignores writes.
// [R2] Under the ring protocol the gateway reads 192.168.100.254 and ignores writes.
// [R3] Setup bit changes act only after flash save and a power cycle.
// [R4] Ethernet error: passive if bit 0 clear, zero velocity if set; bit 1 disables.
// [R5] Under PROFINET the name-clear bit blanks the station name at power-up.
// [R6] Drive-profile bit: 0 selects vendor profile, 1 the standard drive profile.
// [R7] Endless relative with relative mode in CiA402 freezes reported actual position.
// [R8] Under Modbus TCP the mirror bit also maps registers from 0x300.
// [R9] Vendor profile maps five registers per PDO, or eight with the PDO bit.
// [R10] Debounce bit debounces inputs 1 to 4 before mirroring, adding 15 to 25 ms.
// [R11] Output-mirror bit drives module outputs from motor error bits 30 and 31.
// [R12] Input-mirror bit copies module inputs to motor register 210 bits 2 to 5.
// [R13] DHCP only when its bit is set under EtherNet/IP or Modbus TCP.
// [R14] Units bit selects SI units or motor native units for CiA402 set objects.
// [R15] Under PROFINET the swap bit reverses byte order of cyclic data words.
// [R16] Under Sercos the cyclic bit reports external encoder position and velocity.
// [R17] Output register bit 0 drives output one, bit 1 output two.
// [R18] Motor is updated once every N network cycles, N in bits 0 to 15.
// [R19] Divider and alias are sampled only at power-up or after reset.
// [R20] Under EtherCAT alias bits 0 to 15 give the manual node number.
// [R21] Modbus link supervision times out after N times 100 ms; zero disables.
// [R22] Mask bits select negative and positive limit inputs and their inversion.
// [R23] The controller saves parameters by writing command 16 to the command register.
// [R24] A supervision expiry counts as an Ethernet error and triggers the error action.
`timescale 1ns/10ps
module emcr_config_regs #(
    parameter int DEBOUNCE_CYCLES = emcr_pkg::DEBOUNCE_CYCLES,
    parameter int TIMEOUT_CYCLES  = emcr_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire emcr_pkg::emcr_req_t   req,
    output emcr_pkg::emcr_rsp_t        rsp,
    input  wire emcr_pkg::emcr_proto_t proto,
    input  wire logic [13:0]           boot_setup,
    input  wire logic [15:0]           boot_divider,
    input  wire logic [15:0]           boot_alias,
    input  wire logic                  eth_error,
    input  wire logic                  link_traffic,
    input  wire logic                  net_cycle,
    input  wire logic                  relative_mode,
    input  wire logic [1:0]            motor_error_bits,
    input  wire logic [3:0]            digital_inputs_one_to_four,
    input  wire logic [31:0]           cyc_word_in,
    output logic                       motor_update,
    output logic                       err_passive,
    output logic                       err_brake,
    output logic                       link_timeout,
    output logic                       first_output,
    output logic                       second_output,
    output logic [3:0]                 negative_limit_select,
    output logic [3:0]                 positive_limit_select,
    output logic [3:0]                 motor_reg210_bits,
    output logic [31:0]                cyc_word_out,
    output emcr_pkg::emcr_mode_t       mode
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] swap_bytes(input logic [31:0] w);
        swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap_bytes

    function automatic logic [31:0] read_word(input emcr_pkg::emcr_state_t s,
                                              input logic [5:0] idx,
                                              input logic ring);
        read_word = 32'h0000_0000;
        case (idx)
            emcr_pkg::IDX_SUBNET_MASK:    read_word = ring ? emcr_pkg::FIXED_SUBNET_MASK
                                                           : s.subnet;
            emcr_pkg::IDX_GATEWAY:        read_word = ring ? emcr_pkg::FIXED_GATEWAY
                                                           : s.gateway;
            emcr_pkg::IDX_SETUP_FLAGS:    read_word = {18'h0, s.setup};
            emcr_pkg::IDX_OUTPUT_DRIVE:   read_word = {30'h0, s.out_drive};
            emcr_pkg::IDX_UPDATE_DIVIDER: read_word = {16'h0, s.divider};
            emcr_pkg::IDX_NODE_ALIAS:     read_word = {16'h0, s.alias_num};
            emcr_pkg::IDX_LINK_TIMEOUT:   read_word = {16'h0, s.timeout};
            emcr_pkg::IDX_INPUT_MASK:     read_word = {12'h0, s.in_mask};
            default:                      read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    localparam int SETUP_W_L = emcr_pkg::SETUP_W;

    emcr_pkg::emcr_state_t st_r;
    emcr_pkg::emcr_state_t st_nxt;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic       ring;
        logic       wr;
        logic       err_evt;
        logic [3:0] pins;
        logic [3:0] inv_pins;
        logic [SETUP_W_L-1:0] a;
        ring     = 1'b0;
        wr       = 1'b0;
        err_evt  = 1'b0;
        pins     = 4'h0;
        inv_pins = 4'h0;
        a        = '0;
        st_nxt   = st_r;
        ring     = (proto == emcr_pkg::PROTO_POWERLINK);
        wr       = req.valid && req.write;
        a        = st_r.act_setup;

        // Flash image is taken once, at the first edge after reset release.
        // [R19] boot sampling
        if (!st_r.booted)
        begin
            st_nxt.booted      = 1'b1;
            st_nxt.setup       = boot_setup;
            st_nxt.act_setup   = boot_setup;
            st_nxt.divider     = boot_divider;
            st_nxt.act_divider = boot_divider;
            st_nxt.alias_num   = boot_alias;
            st_nxt.act_alias   = boot_alias;
        end

        // Register writes touch only the stored copies, never the active setup.
        // [R3] deferred setup
        if (wr)
        begin
            case (req.index)
                // [R1] [R2] fixed addresses
                emcr_pkg::IDX_SUBNET_MASK:    if (!ring) st_nxt.subnet = req.wdata;
                emcr_pkg::IDX_GATEWAY:        if (!ring) st_nxt.gateway = req.wdata;
                emcr_pkg::IDX_SETUP_FLAGS:    st_nxt.setup = req.wdata[SETUP_W_L-1:0];
                emcr_pkg::IDX_OUTPUT_DRIVE:   st_nxt.out_drive = req.wdata[1:0];
                emcr_pkg::IDX_UPDATE_DIVIDER: st_nxt.divider = req.wdata[15:0];
                emcr_pkg::IDX_NODE_ALIAS:     st_nxt.alias_num = req.wdata[15:0];
                emcr_pkg::IDX_LINK_TIMEOUT:   st_nxt.timeout = req.wdata[15:0];
                emcr_pkg::IDX_INPUT_MASK:     st_nxt.in_mask = req.wdata[19:0] & 20'hf_0f0f;
                default:                      st_nxt.rsp.rdata = st_r.rsp.rdata;
            endcase
        end
        st_nxt.rsp.valid = req.valid;
        st_nxt.rsp.rdata = (req.valid && !req.write) ? read_word(st_r, req.index, ring)
                                                      : 32'h0000_0000;

        // Input synchroniser, then a settle timer that clears whenever the input matches the debounced value.
        st_nxt.in_s1 = digital_inputs_one_to_four;
        st_nxt.in_s2 = st_r.in_s1;
        // [R10] input debounce
        if (st_r.in_s2 != st_r.in_db)
        begin
            if (st_r.db_cnt == 20'(DEBOUNCE_CYCLES - 1))
            begin
                st_nxt.in_db  = st_r.in_s2;
                st_nxt.db_cnt = 20'h0_0000;
            end
            else
            begin
                st_nxt.db_cnt = st_r.db_cnt + 20'h0_0001;
            end
        end
        else
        begin
            st_nxt.db_cnt = 20'h0_0000;
        end
        pins = a[emcr_pkg::SB_DEBOUNCE] ? st_r.in_db : st_r.in_s2;

        // [R12] input mirror
        st_nxt.mirror_bits = a[emcr_pkg::SB_IN_MIRROR] ? pins : 4'h0;

        // [R22] limit switch mask
        inv_pins = pins ^ st_r.in_mask[emcr_pkg::INVERT_LSB +: 4];
        st_nxt.neg_limit = inv_pins & st_r.in_mask[emcr_pkg::NEG_LIMIT_LSB +: 4];
        st_nxt.pos_limit = inv_pins & st_r.in_mask[emcr_pkg::POS_LIMIT_LSB +: 4];

        // [R11] [R17] output drive
        if (a[emcr_pkg::SB_OUT_MIRROR])
        begin
            st_nxt.first_output  = motor_error_bits[0];
            st_nxt.second_output = motor_error_bits[1];
        end
        else
        begin
            st_nxt.first_output  = st_r.out_drive[0];
            st_nxt.second_output = st_r.out_drive[1];
        end

        // A divider of zero behaves as one: every network cycle updates the motor.
        // [R18] poll division
        st_nxt.motor_update = 1'b0;
        if (net_cycle)
        begin
            if ({1'b0, st_r.div_cnt} + 17'h0_0001 >= {1'b0, st_r.act_divider})
            begin
                st_nxt.motor_update = 1'b1;
                st_nxt.div_cnt      = 16'h0000;
            end
            else
            begin
                st_nxt.div_cnt = st_r.div_cnt + 16'h0001;
            end
        end

        // [R21] link supervision
        st_nxt.tmo_expired = 1'b0;
        if (proto != emcr_pkg::PROTO_MODBUS_TCP || st_r.timeout == 16'h0000 || link_traffic)
        begin
            st_nxt.tick_cnt = 22'h00_0000;
            st_nxt.tmo_cnt  = 16'h0000;
        end
        else if (st_r.tick_cnt == 22'(TIMEOUT_CYCLES - 1))
        begin
            st_nxt.tick_cnt = 22'h00_0000;
            if (st_r.tmo_cnt + 16'h0001 >= st_r.timeout)
            begin
                st_nxt.tmo_expired = 1'b1;
                st_nxt.tmo_cnt     = 16'h0000;
            end
            else
            begin
                st_nxt.tmo_cnt = st_r.tmo_cnt + 16'h0001;
            end
        end
        else
        begin
            st_nxt.tick_cnt = st_r.tick_cnt + 22'h00_0001;
        end

        // [R4] [R24] error action
        err_evt = eth_error || st_r.tmo_expired;
        st_nxt.err_passive = err_evt && !a[emcr_pkg::SB_ERR_DISABLE]
                             && !a[emcr_pkg::SB_ERR_BRAKE];
        st_nxt.err_brake   = err_evt && !a[emcr_pkg::SB_ERR_DISABLE]
                             && a[emcr_pkg::SB_ERR_BRAKE];

        // [R15] byte swap
        st_nxt.cyc_out = st_r.mode.swap ? swap_bytes(cyc_word_in) : cyc_word_in;

        // [R5] [R6] [R7] [R8] [R9] [R13] [R14] [R16] [R20] mode decode
        st_nxt.mode.name_clear    = a[emcr_pkg::SB_NAME_CLEAR]
                                    && proto == emcr_pkg::PROTO_PROFINET;
        st_nxt.mode.std_profile   = a[emcr_pkg::SB_STD_PROFILE];
        st_nxt.mode.hold_position = a[emcr_pkg::SB_ENDLESS_REL] && relative_mode
                                    && a[emcr_pkg::SB_STD_PROFILE]
                                    && proto == emcr_pkg::PROTO_ETHERCAT;
        st_nxt.mode.reg_mirror    = a[emcr_pkg::SB_REG_MIRROR]
                                    && proto == emcr_pkg::PROTO_MODBUS_TCP;
        st_nxt.mode.pdo_regs      = a[emcr_pkg::SB_PDO_EIGHT] ? emcr_pkg::PDO_REGS_VENDOR_LONG
                                                               : emcr_pkg::PDO_REGS_VENDOR_SHORT;
        st_nxt.mode.dhcp          = a[emcr_pkg::SB_DHCP]
                                    && (proto == emcr_pkg::PROTO_ETHERNETIP
                                        || proto == emcr_pkg::PROTO_MODBUS_TCP);
        st_nxt.mode.native_units  = a[emcr_pkg::SB_NATIVE_UNITS];
        st_nxt.mode.swap          = a[emcr_pkg::SB_SWAP_BYTES]
                                    && proto == emcr_pkg::PROTO_PROFINET;
        st_nxt.mode.ext_encoder   = a[emcr_pkg::SB_ALT_CYCLIC]
                                    && proto == emcr_pkg::PROTO_SERCOS;
        st_nxt.mode.node_alias    = (proto == emcr_pkg::PROTO_ETHERCAT) ? st_r.act_alias
                                                                        : 16'h0000;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rsp                   = st_r.rsp;
    assign motor_update          = st_r.motor_update;
    assign err_passive           = st_r.err_passive;
    assign err_brake             = st_r.err_brake;
    assign link_timeout          = st_r.tmo_expired;
    assign first_output          = st_r.first_output;
    assign second_output         = st_r.second_output;
    assign negative_limit_select = st_r.neg_limit;
    assign positive_limit_select = st_r.pos_limit;
    assign motor_reg210_bits     = st_r.mirror_bits;
    assign cyc_word_out          = st_r.cyc_out;
    assign mode                  = st_r.mode;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence ring_read_s(logic [5:0] idx);
        req.valid && !req.write && req.index == idx
            && proto == emcr_pkg::PROTO_POWERLINK;
    endsequence

    sequence out_write_s;
        st_r.booted && req.valid && req.write && req.index == emcr_pkg::IDX_OUTPUT_DRIVE
            && !st_r.act_setup[emcr_pkg::SB_OUT_MIRROR];
    endsequence

    netmask_fixed_a: assert property ( // [R1]
        ring_read_s(emcr_pkg::IDX_SUBNET_MASK) |=> rsp.valid
            && rsp.rdata == emcr_pkg::FIXED_SUBNET_MASK)
        else $error("Netmask read under ring protocol is not fixed.");

    gateway_locked_a: assert property ( // [R2]
        st_r.booted && req.valid && req.write && req.index == emcr_pkg::IDX_GATEWAY
            && proto == emcr_pkg::PROTO_POWERLINK |=> $stable(st_r.gateway))
        else $error("Gateway changed by a write under ring protocol.");

    setup_deferred_a: assert property ( // [R3]
        st_r.booted |=> $stable(st_r.act_setup) && $stable(st_r.act_divider))
        else $error("Active setup changed after boot.");

    err_passive_a: assert property ( // [R4]
        eth_error && !st_r.act_setup[emcr_pkg::SB_ERR_DISABLE]
            && !st_r.act_setup[emcr_pkg::SB_ERR_BRAKE] |=> err_passive && !err_brake)
        else $error("Ethernet error did not give passive action.");

    err_disabled_a: assert property ( // [R4]
        st_r.act_setup[emcr_pkg::SB_ERR_DISABLE] && $past(st_r.act_setup[1])
            |-> !err_passive && !err_brake)
        else $error("Error action taken while disabled.");

    out_drive_a: assert property ( // [R17]
        out_write_s ##1 !st_r.act_setup[emcr_pkg::SB_OUT_MIRROR]
            |=> first_output == $past(req.wdata[0], 2)
                && second_output == $past(req.wdata[1], 2))
        else $error("Output register value not on outputs.");

    dhcp_gate_a: assert property ( // [R13]
        mode.dhcp |-> $past(st_r.act_setup[emcr_pkg::SB_DHCP])
            && ($past(proto) == emcr_pkg::PROTO_ETHERNETIP
                || $past(proto) == emcr_pkg::PROTO_MODBUS_TCP))
        else $error("DHCP enabled outside its protocols.");

    poll_update_a: assert property ( // [R18]
        motor_update |-> $past(net_cycle) && st_r.div_cnt == 16'h0000)
        else $error("Motor update not on a counted network cycle.");

    swap_order_a: assert property ( // [R15]
        st_r.mode.swap |=> cyc_word_out == swap_bytes($past(cyc_word_in)))
        else $error("Cyclic word not byte swapped.");

    expiry_error_a: assert property ( // [R24]
        link_timeout && !st_r.act_setup[emcr_pkg::SB_ERR_DISABLE] |=> err_passive || err_brake)
        else $error("Supervision expiry gave no error action.");

endmodule : emcr_config_regs

// >>> shared/emcr_pkg.sv
// Purpose: Constants and types for the Ethernet module configuration register bank.
// Assumes: 40 MHz core clock; register access by register number, one 32-bit word each.
// Notes:   Every offset, field position, fixed value and timing count lives here.
package emcr_pkg;

    // ------------------------------------------------------------------
    // Register numbers and fields
    // ------------------------------------------------------------------
    localparam logic [5:0]  IDX_SUBNET_MASK    = 6'h04;
    localparam logic [5:0]  IDX_GATEWAY        = 6'h05;
    localparam logic [5:0]  IDX_SETUP_FLAGS    = 6'h06;
    localparam logic [5:0]  IDX_OUTPUT_DRIVE   = 6'h07;
    localparam logic [5:0]  IDX_UPDATE_DIVIDER = 6'h08;
    localparam logic [5:0]  IDX_NODE_ALIAS     = 6'h09;
    localparam logic [5:0]  IDX_LINK_TIMEOUT   = 6'h0a;
    localparam logic [5:0]  IDX_INPUT_MASK     = 6'h0b;

    localparam logic [31:0] FIXED_SUBNET_MASK  = 32'hffff_ff00;
    localparam logic [31:0] FIXED_GATEWAY      = 32'hc0a8_64fe;

    localparam int SB_ERR_BRAKE     = 0;
    localparam int SB_ERR_DISABLE   = 1;
    localparam int SB_NAME_CLEAR    = 2;
    localparam int SB_STD_PROFILE   = 3;
    localparam int SB_ENDLESS_REL   = 4;
    localparam int SB_REG_MIRROR    = 5;
    localparam int SB_PDO_EIGHT     = 6;
    localparam int SB_DEBOUNCE      = 7;
    localparam int SB_OUT_MIRROR    = 8;
    localparam int SB_IN_MIRROR     = 9;
    localparam int SB_DHCP          = 10;
    localparam int SB_NATIVE_UNITS  = 11;
    localparam int SB_SWAP_BYTES    = 12;
    localparam int SB_ALT_CYCLIC    = 13;
    localparam int SETUP_W          = 14;

    localparam int NEG_LIMIT_LSB    = 0;
    localparam int POS_LIMIT_LSB    = 8;
    localparam int INVERT_LSB       = 16;
    localparam logic [3:0] PDO_REGS_VENDOR_SHORT = 4'h5;
    localparam logic [3:0] PDO_REGS_VENDOR_LONG  = 4'h8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ          = 40_000_000;
    localparam int DEBOUNCE_MS     = 20;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int TIMEOUT_UNIT_MS = 100;
    localparam int TIMEOUT_CYCLES  = TIMEOUT_UNIT_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PROTO_ETHERCAT   = 3'h0,
        PROTO_ETHERNETIP = 3'h1,
        PROTO_MODBUS_TCP = 3'h2,
        PROTO_PROFINET   = 3'h3,
        PROTO_POWERLINK  = 3'h4,
        PROTO_SERCOS     = 3'h5
    } emcr_proto_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [5:0]  index;
        logic [31:0] wdata;
    } emcr_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } emcr_rsp_t;

    typedef struct packed {
        logic       name_clear;
        logic       std_profile;
        logic       hold_position;
        logic       reg_mirror;
        logic [3:0] pdo_regs;
        logic       dhcp;
        logic       native_units;
        logic       swap;
        logic       ext_encoder;
        logic [15:0] node_alias;
    } emcr_mode_t;

    typedef struct packed {
        logic        booted;
        logic [31:0] subnet;
        logic [31:0] gateway;
        logic [SETUP_W-1:0] setup;
        logic [1:0]  out_drive;
        logic [15:0] divider;
        logic [15:0] alias_num;
        logic [15:0] timeout;
        logic [19:0] in_mask;
        logic [SETUP_W-1:0] act_setup;
        logic [15:0] act_divider;
        logic [15:0] act_alias;
        emcr_rsp_t   rsp;
        logic [3:0]  in_s1;
        logic [3:0]  in_s2;
        logic [3:0]  in_db;
        logic [19:0] db_cnt;
        logic [15:0] div_cnt;
        logic        motor_update;
        logic [21:0] tick_cnt;
        logic [15:0] tmo_cnt;
        logic        tmo_expired;
        logic        err_passive;
        logic        err_brake;
        logic        first_output;
        logic        second_output;
        logic [3:0]  neg_limit;
        logic [3:0]  pos_limit;
        logic [3:0]  mirror_bits;
        logic [31:0] cyc_out;
        emcr_mode_t  mode;
    } emcr_state_t;

endpackage : emcr_pkg

// >>> tb/emcr_master_model.sv
// Purpose: Fieldbus master side: paces the network cycle.
// Assumes: The master shares the clock of the register bank.
// Notes:   One network cycle pulse every four clocks while run is high.
`timescale 1ns/10ps
module emcr_master_model (
    input  wire logic clk,
    input  wire logic run,
    output logic      net_cycle
);
    logic [1:0] ph_r;
    initial
    begin
        ph_r = 2'h0;
        net_cycle = 1'b0;
    end
    always @(posedge clk)
    begin
        ph_r <= run ? ph_r + 2'h1 : 2'h0;
        net_cycle <= run && (ph_r == 2'h3);
    end
endmodule : emcr_master_model

// >>> tb/tb_ethernet_module_config_regs.sv
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: Short debounce and timeout counts; boot image fixed at time zero.
// Notes:   Registers are reached by register number, one word per request.
`timescale 1ns/10ps
module tb_ethernet_module_config_regs;
    logic                  clk = 1'b0;
    logic                  nrst = 1'b0;
    emcr_pkg::emcr_req_t   req = '0;
    emcr_pkg::emcr_rsp_t   rsp;
    emcr_pkg::emcr_proto_t proto = emcr_pkg::PROTO_PROFINET;
    logic                  eth_error = 1'b0;
    logic                  run = 1'b0;
    logic                  link_traffic = 1'b0, relative_mode = 1'b0;
    logic [1:0]            merr = 2'h0;
    logic [3:0]            din = 4'h0;
    logic [31:0]           cyc_in = 32'h1122_3344;
    logic                  net_cycle, motor_update, err_passive, err_brake, link_timeout;
    logic                  first_output, second_output;
    logic [3:0]            neg_l, pos_l, reg210;
    logic [31:0]           cyc_out;
    emcr_pkg::emcr_mode_t  mode;
    int                    miscompares = 0, n_tests = 0, nc = 0, mu = 0, k;

    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (net_cycle === 1'b1) nc++;
        if (motor_update === 1'b1) mu++;
    end

    emcr_master_model u_emcr_master_model (.clk(clk), .run(run), .net_cycle(net_cycle));

    // the boot image stands for the copy saved to flash.
    emcr_config_regs #(.DEBOUNCE_CYCLES(8), .TIMEOUT_CYCLES(10)) u_emcr_config_regs (
        .clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .proto(proto),
        .boot_setup(14'h1040), .boot_divider(16'h0003), .boot_alias(16'h0042),
        .eth_error(eth_error), .link_traffic(link_traffic), .net_cycle(net_cycle),
        .relative_mode(relative_mode), .motor_error_bits(merr),
        .digital_inputs_one_to_four(din), .cyc_word_in(cyc_in),
        .motor_update(motor_update), .err_passive(err_passive), .err_brake(err_brake),
        .link_timeout(link_timeout), .first_output(first_output),
        .second_output(second_output), .negative_limit_select(neg_l),
        .positive_limit_select(pos_l), .motor_reg210_bits(reg210),
        .cyc_word_out(cyc_out), .mode(mode));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b1, index: idx, wdata: d};
        @(posedge clk);
        req.valid <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b0, index: idx, wdata: 32'h0};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk({rsp.valid, rsp.rdata}, {1'b1, exp});
    endtask : rd

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(mode.pdo_regs, 4'h8);
        chk(mode.std_profile, 1'b0);
        chk(cyc_out, 32'h4433_2211);
        wr(6'h06, 32'hffff_ffff);
        rd(6'h06, 32'h0000_3fff);
        chk({mode.swap, mode.pdo_regs}, 5'h18);
        wr(6'h07, 32'hffff_ffff);
        rd(6'h07, 32'h0000_0003);
        chk({second_output, first_output}, 2'h3);
        wr(6'h07, 32'h0000_0002);
        repeat (2) @(posedge clk);
        #1;
        chk({second_output, first_output}, 2'h2);
        proto <= emcr_pkg::PROTO_POWERLINK;
        wr(6'h04, 32'h0);
        rd(6'h04, 32'hffff_ff00);
        wr(6'h05, 32'h0);
        rd(6'h05, 32'hc0a8_64fe);
        proto <= emcr_pkg::PROTO_MODBUS_TCP;
        wr(6'h04, 32'h1234_5678);
        rd(6'h04, 32'h1234_5678);
        rd(6'h0c, 32'h0);
        @(posedge clk);
        eth_error <= 1'b1;
        @(posedge clk);
        eth_error <= 1'b0;
        #1;
        chk({err_passive, err_brake}, 2'h2);
        wr(6'h0a, 32'h0000_0002);
        k = 0;
        while (link_timeout !== 1'b1 && k < 60)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(k, 20);
        @(posedge clk);
        #1;
        chk(err_passive, 1'b1);
        wr(6'h0a, 32'h0);
        run <= 1'b1;
        repeat (48) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        chk(mu, nc / 3);
        chk(nc, 12);
        din  <= 4'h3;
        merr <= 2'h3;
        wr(6'h0b, 32'h0001_0f01);
        rd(6'h0b, 32'h0001_0f01);
        repeat (2) @(posedge clk);
        #1;
        chk({neg_l, pos_l, reg210}, 12'h020);
        chk({second_output, first_output}, 2'h2);
        proto <= emcr_pkg::PROTO_ETHERCAT;
        relative_mode <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(mode.node_alias, 16'h0042);
        chk(mode.hold_position, 1'b0);
        finish_test();
    end
endmodule : tb_ethernet_module_config_regs
